// File: rtl/wdt_safety_regs.vh
// Register offsets, field positions and timing constants for the watchdog block
// Function
// R1 - Watchdog load clears expired state and reloads the 32-bit count.
// R2 - Timeout equals loaded count times a 100 ns tick.
// R3 - Host never loads zero; a zero load is rejected.
// R4 - Watchdog enable bit: 0 off (reset default), 1 on.
// R5 - Fallback enable 1 and watchdog interrupt: drive stored safety values out.
// R6 - Fallback enable 0: outputs hold their values on watchdog interrupt.
// R7 - Readable change-interrupt enable bits for bank 0 and bank 1, default off.
// R8 - Readable change-interrupt pending bit per bank, default 0.
// R9 - Readable watchdog pending bit and watchdog enable read-back bit.
// R10 - Two bridge local interrupt lines readable as status bits, default 0.
// R11 - Separate clears for watchdog, bank 0 and bank 1 requests.
// R12 - At power-up drive stored default values onto all 64 outputs; reset clears the stored image, so the boot copy drives all zeros.
// R13 - Default setup registers A..D; writing D starts a 0.5 s flash write.
// R14 - Flash-busy flag shows whether flash write or read has finished.
// R15 - Default read-back request starts flash read after 50 ms.
// R16 - Safety setup registers A..D; writing D starts a 0.5 s flash write.
// R17 - Safety read-back request starts flash read after 50 ms.
// R18 - Output state readable as low and high 32-bit halves.
// R19 - Busy flag reads 0 when finished (default), 1 while in progress.
// R20 - A bank's change latch is erased when its request is cleared.
// R21 - Enabled counter decrements per tick; at zero sets watchdog pending.
// R22 - Loads, setup writes and read-back requests while busy are ignored.
`ifndef WDT_SAFETY_REGS_VH
`define WDT_SAFETY_REGS_VH

// ==========================================================================
// Register offsets (word addresses on the plain port)
`define A_WDT_LOAD    5'h00
`define A_CTRL        5'h01
`define A_STATUS      5'h02
`define A_CLEAR       5'h03
`define A_DO_LO       5'h04
`define A_DO_HI       5'h05
`define A_PUP_SET_A   5'h06
`define A_SAFE_SET_A  5'h0a
`define A_SET_D_OFS   5'h3
`define A_PUP_RB_REQ  5'h0e
`define A_SAFE_RB_REQ 5'h0f
`define A_RB_A        5'h10
`define A_LATCH0      5'h14
`define A_LATCH1      5'h15
`define A_WDT_COUNT   5'h16
`define A_DO_SET_LO   5'h17
`define A_DO_SET_HI   5'h18

// ==========================================================================
// Control fields
`define C_WDT_EN   0
`define C_SAFE_EN  1
`define C_COS0_EN  2
`define C_COS1_EN  3
// Status fields
`define S_COS0_EN  0
`define S_COS1_EN  1
`define S_COS0_P   2
`define S_COS1_P   3
`define S_WDT_EN   4
`define S_WDT_P    5
`define S_LINT1    6
`define S_LINT2    7
`define S_BUSY     8
`define S_ZERO_ERR 9
// Clear fields
`define K_WDT      0
`define K_COS0     1
`define K_COS1     2

// ==========================================================================
// Timing, all at 250 MHz (4 ns)
`define CLK_PERIOD_NS 4
`define TICK_NS       100
`define TICK_CYC      (`TICK_NS / `CLK_PERIOD_NS)
`define FLASH_WR_MS   500
`define FLASH_RD_MS   50
`define CYC_PER_MS    (1000000 / `CLK_PERIOD_NS)
`define FLASH_WR_CYC  (`FLASH_WR_MS * `CYC_PER_MS)
`define FLASH_RD_CYC  (`FLASH_RD_MS * `CYC_PER_MS)

`endif

// File: rtl/sync2.v
// Two-flop synchroniser for one asynchronous level
`timescale 1ns/100ps
`default_nettype none
module sync2 (
  input  wire i_ref_clk,
  input  wire i_rst,
  input  wire i_async,
  output wire o_sync
);
  reg meta_q;
  reg sync_q;

  // First flop feeds only the second
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  assign o_sync = sync_q;
endmodule
`default_nettype wire

// File: rtl/down_timer.v
// Loadable down counter with a done pulse
`timescale 1ns/100ps
`default_nettype none
module down_timer #(
  parameter W = 32
) (
  input  wire         i_ref_clk,
  input  wire         i_rst,
  input  wire         i_load,
  input  wire [W-1:0] i_count,
  input  wire         i_step,
  output wire         o_running,
  output wire         o_done,
  output wire [W-1:0] o_value
);
  reg [W-1:0] cnt_q;
  reg         run_q;

  // Counts down one per step while running
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= {W{1'b0}};
      run_q <= 1'b0;
    end else if (i_load) begin
      cnt_q <= i_count;
      run_q <= (i_count != {W{1'b0}});
    end else if (run_q && i_step) begin
      cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
      if (cnt_q == {{(W-1){1'b0}}, 1'b1})
        run_q <= 1'b0;
    end
  end

  assign o_running = run_q;
  assign o_done    = run_q && i_step &&
                     (cnt_q == {{(W-1){1'b0}}, 1'b1});
  assign o_value   = cnt_q;
endmodule
`default_nettype wire

// File: rtl/watchdog_safety_output_control.v
// Watchdog, safety output and flash-backed default output control
`timescale 1ns/100ps
`default_nettype none
`include "wdt_safety_regs.vh"
module watchdog_safety_output_control #(
  parameter FLASH_WR_CYCLES = `FLASH_WR_CYC,
  parameter FLASH_RD_CYCLES = `FLASH_RD_CYC
) (
  input  wire        i_ref_clk,
  input  wire        i_rst,
  input  wire [4:0]  i_addr,
  input  wire [31:0] i_wdata,
  input  wire        i_wr,
  input  wire        i_rd,
  output reg  [31:0] o_rdata,
  input  wire        i_bank0_change,
  input  wire        i_bank1_change,
  input  wire [63:0] i_din,
  input  wire        i_bridge_local_irq_one,
  input  wire        i_bridge_local_irq_two,
  output wire [63:0] o_dout,
  output wire        o_watchdog_irq,
  output wire        o_bank0_change_irq,
  output wire        o_bank1_change_irq
);
  // ========================================================================
  // Declarations
  localparam [1:0] F_IDLE  = 2'h0;
  localparam [1:0] F_WRITE = 2'h1;
  localparam [1:0] F_READ  = 2'h2;
  localparam [1:0] F_BOOT  = 2'h3;

  reg  [1:0]  fst_q;
  reg         fsel_safe_q;   // Which image the flash job addresses
  reg  [63:0] pup_flash_q;   // Power-up image; reset clears it
  reg  [63:0] safe_flash_q;  // Safety image; reset clears it
  reg  [63:0] stage_pup_q;
  reg  [63:0] stage_safe_q;
  reg  [63:0] rb_q;
  reg  [63:0] dout_q;
  reg  [31:0] reload_q;
  reg  [3:0]  ctrl_q;
  reg         wdt_pend_q;
  reg         cos0_pend_q;
  reg         cos1_pend_q;
  reg  [31:0] latch0_q;
  reg  [31:0] latch1_q;
  reg         zero_err_q;
  reg  [4:0]  tick_q;
  wire        tick;
  wire        busy;
  wire        wdt_done;
  wire [31:0] wdt_val;
  wire        fl_run;
  wire        fl_done;
  wire        fl_load;
  wire [31:0] fl_count;
  wire        cos0_s;
  wire        cos1_s;
  wire        lint1_s;
  wire        lint2_s;
  reg  [63:0] din_s_q;
  reg  [63:0] din_m_q;
  wire        wr_load;
  wire        load_ok;
  wire        clr_wdt;
  wire        clr_c0;
  wire        clr_c1;
  wire        start_pw;
  wire        start_sw;
  wire        start_pr;
  wire        start_sr;

  // ========================================================================
  // Input synchronisers
  // Change and bridge lines are levels; each gets two flops
  sync2 u_sync_c0 (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
                   .i_async(i_bank0_change), .o_sync(cos0_s));
  sync2 u_sync_c1 (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
                   .i_async(i_bank1_change), .o_sync(cos1_s));
  sync2 u_sync_l1 (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
                   .i_async(i_bridge_local_irq_one), .o_sync(lint1_s));
  sync2 u_sync_l2 (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
                   .i_async(i_bridge_local_irq_two), .o_sync(lint2_s));

  // Input data bus, two flops deep
  // Only the second stage is read; the first may still be settling
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      din_m_q <= 64'h0;
      din_s_q <= 64'h0;
    end else begin
      din_m_q <= i_din;
      din_s_q <= din_m_q;
    end
  end

  // ========================================================================
  // Write decode
  // R22 busy gating
  assign busy     = (fst_q != F_IDLE);
  assign wr_load  = i_wr && (i_addr == `A_WDT_LOAD) && !busy;
  // R3 only a nonzero load reaches the counter
  assign load_ok  = wr_load && (i_wdata != 32'h0);
  // R11 separate clears
  assign clr_wdt  = i_wr && (i_addr == `A_CLEAR) && i_wdata[`K_WDT];
  assign clr_c0   = i_wr && (i_addr == `A_CLEAR) && i_wdata[`K_COS0];
  assign clr_c1   = i_wr && (i_addr == `A_CLEAR) && i_wdata[`K_COS1];
  // R13 write D starts
  assign start_pw = i_wr && (i_addr == `A_PUP_SET_A + `A_SET_D_OFS) && !busy;
  // R16 write D starts
  assign start_sw = i_wr && (i_addr == `A_SAFE_SET_A + `A_SET_D_OFS) && !busy;
  // R15 read-back request
  assign start_pr = i_wr && (i_addr == `A_PUP_RB_REQ) && !busy;
  // R17 read-back request
  assign start_sr = i_wr && (i_addr == `A_SAFE_RB_REQ) && !busy;

  // ========================================================================
  // Watchdog timebase and counter
  // R2 100 ns tick
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst)
      tick_q <= 5'h0;
    // A refused zero load leaves the timebase running
    else if (tick || load_ok)
      tick_q <= 5'h0;
    else
      tick_q <= tick_q + 5'h1;
  end
  assign tick = (tick_q == (`TICK_CYC - 1));

  // R21 decrement while enabled
  down_timer #(.W(32)) u_wdt (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_load    (load_ok),
    .i_count   (i_wdata),
    .i_step    (tick && ctrl_q[`C_WDT_EN]),
    .o_running (),
    .o_done    (wdt_done),
    .o_value   (wdt_val)
  );

  // ========================================================================
  // Control, reload and zero-load error
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctrl_q     <= 4'h0;
      reload_q   <= 32'h0;
      zero_err_q <= 1'b0;
    end else begin
      // R4 enable bit
      if (i_wr && (i_addr == `A_CTRL))
        ctrl_q <= i_wdata[3:0];
      // R3 zero load rejected
      // Error bit stands until the next load
      if (wr_load) begin
        zero_err_q <= (i_wdata == 32'h0);
        if (i_wdata != 32'h0)
          reload_q <= i_wdata;
      end
    end
  end

  // ========================================================================
  // Interrupt pending flags; setting wins over clearing
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      wdt_pend_q  <= 1'b0;
      cos0_pend_q <= 1'b0;
      cos1_pend_q <= 1'b0;
      latch0_q    <= 32'h0;
      latch1_q    <= 32'h0;
    end else begin
      // R21 set at zero
      if (wdt_done)
        wdt_pend_q <= 1'b1;
      // R1 load clears expiry
      else if (clr_wdt || load_ok)
        wdt_pend_q <= 1'b0;
      // R20 latch on change
      if (cos0_s && ctrl_q[`C_COS0_EN]) begin
        cos0_pend_q <= 1'b1;
        latch0_q    <= din_s_q[31:0];
      end else if (clr_c0) begin
        cos0_pend_q <= 1'b0;
        latch0_q    <= 32'h0;
      end
      if (cos1_s && ctrl_q[`C_COS1_EN]) begin
        cos1_pend_q <= 1'b1;
        latch1_q    <= din_s_q[63:32];
      end else if (clr_c1) begin
        cos1_pend_q <= 1'b0;
        latch1_q    <= 32'h0;
      end
    end
  end

  // ========================================================================
  // Flash job timer: write and read-back jobs; the boot copy does not use it
  // Write and read jobs share one timer; only one runs at a time
  assign fl_load  = start_pw || start_sw || start_pr || start_sr;
  assign fl_count = (start_pw || start_sw) ? FLASH_WR_CYCLES[31:0]
                                           : FLASH_RD_CYCLES[31:0];

  down_timer #(.W(32)) u_flash (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_load    (fl_load),
    .i_count   (fl_count),
    .i_step    (1'b1),
    .o_running (fl_run),
    .o_done    (fl_done),
    .o_value   ()
  );

  // R14 flash procedure sequencer
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      fst_q       <= F_BOOT;
      fsel_safe_q <= 1'b0;
    end else begin
      case (fst_q)
        F_IDLE: begin
          if (start_pw || start_sw) begin
            fst_q       <= F_WRITE;
            fsel_safe_q <= start_sw;
          end else if (start_pr || start_sr) begin
            fst_q       <= F_READ;
            fsel_safe_q <= start_sr;
          end
        end
        // A stopped timer also ends the job, so busy can never stick
        F_WRITE, F_READ: begin
          if (fl_done || !fl_run)
            fst_q <= F_IDLE;
        end
        // Boot copy holds busy for one cycle
        F_BOOT: fst_q <= F_IDLE;
        default: fst_q <= F_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Setup staging, flash images and read-back data
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      stage_pup_q  <= 64'h0;
      stage_safe_q <= 64'h0;
      pup_flash_q  <= 64'h0;
      safe_flash_q <= 64'h0;
      rb_q         <= 64'h0;
    end else begin
      // R13 default staging
      if (i_wr && !busy && (i_addr >= `A_PUP_SET_A) &&
          (i_addr <= `A_PUP_SET_A + `A_SET_D_OFS))
        stage_pup_q[16*(i_addr-`A_PUP_SET_A) +: 16] <= i_wdata[15:0];
      // R16 safety staging
      if (i_wr && !busy && (i_addr >= `A_SAFE_SET_A) &&
          (i_addr <= `A_SAFE_SET_A + `A_SET_D_OFS))
        stage_safe_q[16*(i_addr-`A_SAFE_SET_A) +: 16] <= i_wdata[15:0];
      // Commit the staged image; the bus has moved on by now
      if (fl_done && (fst_q == F_WRITE)) begin
        if (fsel_safe_q)
          safe_flash_q <= stage_safe_q;
        else
          pup_flash_q  <= stage_pup_q;
      end
      // Word D lands with the start strobe
      if (start_pw)
        stage_pup_q[63:48] <= i_wdata[15:0];
      if (start_sw)
        stage_safe_q[63:48] <= i_wdata[15:0];
      // R15 read-back lands
      if (fl_done && (fst_q == F_READ))
        rb_q <= fsel_safe_q ? safe_flash_q : pup_flash_q;
    end
  end

  // ========================================================================
  // Output drive
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      dout_q <= 64'h0;
    end else if (fst_q == F_BOOT) begin
      // R12 power-up defaults
      dout_q <= pup_flash_q;
    end else if (wdt_done && ctrl_q[`C_SAFE_EN]) begin
      // R5 safety values out
      dout_q <= safe_flash_q;
    end else if (i_wr && (i_addr == `A_DO_SET_LO)) begin
      // Software writes lose to the boot copy and the fallback
      dout_q[31:0] <= i_wdata;
    end else if (i_wr && (i_addr == `A_DO_SET_HI)) begin
      dout_q[63:32] <= i_wdata;
    end
    // R6 otherwise outputs hold
  end

  // ========================================================================
  // Read mux, data one cycle after the strobe
  always @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 32'h0;
    end else if (i_rd) begin
      case (i_addr)
        `A_WDT_LOAD:   o_rdata <= reload_q;
        `A_CTRL:       o_rdata <= {28'h0, ctrl_q};
        // R7 R8 R9 R10 R19 status word
        `A_STATUS:     o_rdata <= {22'h0, zero_err_q, busy, lint2_s,
                                   lint1_s, wdt_pend_q,
                                   ctrl_q[`C_WDT_EN], cos1_pend_q,
                                   cos0_pend_q, ctrl_q[`C_COS1_EN],
                                   ctrl_q[`C_COS0_EN]};
        // R18 output halves
        `A_DO_LO:      o_rdata <= dout_q[31:0];
        `A_DO_HI:      o_rdata <= dout_q[63:32];
        `A_RB_A:       o_rdata <= {16'h0, rb_q[15:0]};
        `A_RB_A + 5'h1: o_rdata <= {16'h0, rb_q[31:16]};
        `A_RB_A + 5'h2: o_rdata <= {16'h0, rb_q[47:32]};
        `A_RB_A + 5'h3: o_rdata <= {16'h0, rb_q[63:48]};
        `A_LATCH0:     o_rdata <= latch0_q;
        `A_LATCH1:     o_rdata <= latch1_q;
        // Live count for software polling
        `A_WDT_COUNT:  o_rdata <= wdt_val;
        default:       o_rdata <= 32'h0;
      endcase
    end else begin
      // Idle cycles return zero
      o_rdata <= 32'h0;
    end
  end

  // Pending flags drive the interrupt pins
  assign o_dout             = dout_q;
  assign o_watchdog_irq     = wdt_pend_q;
  assign o_bank0_change_irq = cos0_pend_q;
  assign o_bank1_change_irq = cos1_pend_q;
endmodule
`default_nettype wire

// File: verif/wdt_safety_props.sv
// Checker for the watchdog safety output block
`timescale 1ns/100ps
`default_nettype none
`include "wdt_safety_regs.vh"
module wdt_safety_props (
  input wire logic        i_ref_clk,
  input wire logic        i_rst,
  input wire logic [4:0]  i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wr,
  input wire logic        i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic        i_bank0_change,
  input wire logic [63:0] o_dout,
  input wire logic        o_watchdog_irq,
  input wire logic        o_bank0_change_irq
);
  logic [3:0] ctl_q;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  // Shadow of the control bits
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      ctl_q <= 4'h0;
    end else if (i_wr && i_addr == `A_CTRL) begin
      ctl_q <= i_wdata[3:0];
    end
  end

  // ==========================================================================
  // Watchdog
  // load clears pending
  a_load_clears: assert property (
    i_wr && i_addr == `A_WDT_LOAD && i_wdata != 32'h0 |=> !o_watchdog_irq)
    else $error("watchdog pending survived a load");
  a_zero_refused: assert property (
    i_wr && i_addr == `A_WDT_LOAD && i_wdata == 32'h0 && o_watchdog_irq
    |=> o_watchdog_irq) else $error("zero load was taken");
  a_off_no_irq: assert property (
    !$past(ctl_q[`C_WDT_EN]) |-> !$rose(o_watchdog_irq))
    else $error("watchdog fired while disabled");
  a_safety_off: assert property (
    $rose(o_watchdog_irq) && !$past(ctl_q[`C_SAFE_EN]) |-> $stable(o_dout))
    else $error("outputs moved with fallback off");

  // ==========================================================================
  // Change interrupts and read-back
  // bank pending raised
  a_bank_raise: assert property (
    $rose(i_bank0_change) && ctl_q[`C_COS0_EN] |-> ##[1:6] o_bank0_change_irq)
    else $error("bank 0 change not flagged");
  a_status_mirror: assert property (
    i_rd && i_addr == `A_STATUS |=> o_rdata[`S_WDT_P] == $past(o_watchdog_irq)
    && o_rdata[`S_COS0_P] == $past(o_bank0_change_irq))
    else $error("status pending bits wrong");
  a_clear_drops: assert property (
    i_wr && i_addr == `A_CLEAR && i_wdata[`K_COS0] |=> !o_bank0_change_irq)
    else $error("bank 0 clear ignored");
  a_dout_lo: assert property (
    i_rd && i_addr == `A_DO_LO |=> o_rdata == $past(o_dout[31:0]))
    else $error("low output half misread");
  a_dout_hi: assert property (
    i_rd && i_addr == `A_DO_HI |=> o_rdata == $past(o_dout[63:32]))
    else $error("high output half misread");

  // Main scenarios reached
  c_safety: cover property (o_watchdog_irq && ctl_q[`C_SAFE_EN]);
  c_bank: cover property ($rose(o_bank0_change_irq));
  c_zero: cover property (i_wr && i_addr == `A_WDT_LOAD && i_wdata == 32'h0);
endmodule

bind watchdog_safety_output_control wdt_safety_props u_props (
  .i_ref_clk          (i_ref_clk),
  .i_rst              (i_rst),
  .i_addr             (i_addr),
  .i_wdata            (i_wdata),
  .i_wr               (i_wr),
  .i_rd               (i_rd),
  .o_rdata            (o_rdata),
  .i_bank0_change     (i_bank0_change),
  .o_dout             (o_dout),
  .o_watchdog_irq     (o_watchdog_irq),
  .o_bank0_change_irq (o_bank0_change_irq)
);
`default_nettype wire

// File: verif/wdt_host_model.sv
// Host software model driving the register port
`timescale 1ns/100ps
`default_nettype none
`include "wdt_safety_regs.vh"
module wdt_host_model (
  input  wire logic        i_ref_clk,
  input  wire logic [31:0] i_rdata,
  output var  logic [4:0]  o_addr,
  output var  logic [31:0] o_wdata,
  output var  logic        o_wr,
  output var  logic        o_rd
);
  // Idle bus at time zero
  initial begin
    o_addr = 5'h00;
    o_wdata = 32'h0;
    o_wr = 1'b0;
    o_rd = 1'b0;
  end

  // One-cycle write strobe
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_wdata <= d;
    o_wr <= 1'b1;
    @(posedge i_ref_clk);
    o_wr <= 1'b0;
  endtask

  // One-cycle read, data taken the cycle after
  task automatic rd_reg(input logic [4:0] a, output logic [31:0] d);
    @(posedge i_ref_clk);
    o_addr <= a;
    o_rd <= 1'b1;
    @(posedge i_ref_clk);
    o_rd <= 1'b0;
    @(posedge i_ref_clk);
    d = i_rdata;
  endtask

  task automatic wait_idle;
    logic [31:0] s;
    s = 32'h100;
    repeat (100) if (s[`S_BUSY]) rd_reg(`A_STATUS, s);
  endtask

  task automatic set64(input logic [4:0] base, input logic [63:0] v);
    for (int i = 0; i < 4; i++) wr_reg(base + 5'(i), {16'h0, v[16*i +: 16]});
    wait_idle();
  endtask

  task automatic get64(input logic [4:0] req, output logic [63:0] v);
    logic [31:0] r;
    wr_reg(req, 32'h1);
    wait_idle();
    for (int i = 0; i < 4; i++) begin
      rd_reg(`A_RB_A + 5'(i), r);
      v[16*i +: 16] = r[15:0];
    end
  endtask
endmodule
`default_nettype wire

// File: verif/watchdog_safety_output_control_tb.sv
// Self-checking bench for the watchdog safety output block
`timescale 1ns/100ps
`default_nettype none
`include "wdt_safety_regs.vh"
module watchdog_safety_output_control_tb;
  localparam logic [63:0] SAFE = 64'hc3c3_5a5a_0f0f_9696;
  localparam logic [63:0] PUP  = 64'h1234_5678_9abc_def0;
  localparam logic [63:0] DIN  = 64'h0123_4567_89ab_cdef;
  typedef struct { logic w; logic [4:0] a; logic [31:0] d; } row_t;
  logic        i_ref_clk;
  logic        i_rst;
  logic [4:0]  i_addr;
  logic [31:0] i_wdata;
  logic        i_wr;
  logic        i_rd;
  logic [31:0] o_rdata;
  logic [1:0]  chg;
  logic [1:0]  lint;
  logic [1:0]  birq;
  logic [63:0] i_din;
  logic [63:0] o_dout;
  logic [63:0] v;
  logic [31:0] r;
  logic        o_watchdog_irq;
  int          mismatches;
  int          compares;
  int          cycles;
  int          n;
  // Reads carry the expected value in d
  row_t rows [11] = '{
    '{1'b0, `A_STATUS, 32'h0}, '{1'b1, `A_CTRL, 32'hc},
    '{1'b0, `A_CTRL, 32'hc}, '{1'b0, `A_STATUS, 32'h3},
    '{1'b1, `A_CTRL, 32'h0}, '{1'b0, `A_STATUS, 32'h0}, '{1'b0, 5'h1f, 32'h0},
    '{1'b1, `A_DO_SET_LO, 32'h9abcdef0}, '{1'b1, `A_DO_SET_HI, 32'h12345678},
    '{1'b0, `A_DO_LO, 32'h9abcdef0}, '{1'b0, `A_DO_HI, 32'h12345678}};

  watchdog_safety_output_control #(
    .FLASH_WR_CYCLES (20),
    .FLASH_RD_CYCLES (10)
  ) u_dut (
    .i_ref_clk              (i_ref_clk),
    .i_rst                  (i_rst),
    .i_addr                 (i_addr),
    .i_wdata                (i_wdata),
    .i_wr                   (i_wr),
    .i_rd                   (i_rd),
    .o_rdata                (o_rdata),
    .i_bank0_change         (chg[0]),
    .i_bank1_change         (chg[1]),
    .i_din                  (i_din),
    .i_bridge_local_irq_one (lint[0]),
    .i_bridge_local_irq_two (lint[1]),
    .o_dout                 (o_dout),
    .o_watchdog_irq         (o_watchdog_irq),
    .o_bank0_change_irq     (birq[0]),
    .o_bank1_change_irq     (birq[1])
  );

  wdt_host_model u_host (
    .i_ref_clk (i_ref_clk),
    .i_rdata   (o_rdata),
    .o_addr    (i_addr),
    .o_wdata   (i_wdata),
    .o_wr      (i_wr),
    .o_rd      (i_rd)
  );

  // Free-running 250 MHz clock
  initial begin
    i_ref_clk = 1'b0;
    forever #2 i_ref_clk = ~i_ref_clk;
  end

  // Hang guard
  always @(posedge i_ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      mismatches++;
      end_sim();
    end
  end

  // ==========================================================================
  // Helpers
  task automatic check(input string what, input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_irq;
    n = 0;
    while (o_watchdog_irq !== 1'b1 && n < 200) begin
      @(posedge i_ref_clk);
      n++;
    end
  endtask

  task automatic end_sim;
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    i_rst = 1'b1;
    chg = 2'b00;
    lint = 2'b00;
    i_din = DIN;
    mismatches = 0;
    compares = 0;
    cycles = 0;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    check("dout after reset", o_dout, 64'h0);
    foreach (rows[i]) begin
      if (rows[i].w) begin
        u_host.wr_reg(rows[i].a, rows[i].d);
      end else begin
        u_host.rd_reg(rows[i].a, r);
        check("register", {32'h0, r}, {32'h0, rows[i].d});
      end
    end
    // Expiry with fallback on, zero load, reload, clear
    u_host.set64(`A_SAFE_SET_A, SAFE);
    u_host.wr_reg(`A_CTRL, 32'h3);
    u_host.wr_reg(`A_WDT_LOAD, 32'h3);
    wait_irq();
    check("interval", 64'(n - 3 * `TICK_CYC), 64'h1);
    check("safety outputs", o_dout, SAFE);
    u_host.rd_reg(`A_STATUS, r);
    check("wdt status", 64'(r[5:4]), 64'h3);
    u_host.wr_reg(`A_WDT_LOAD, 32'h0);
    u_host.rd_reg(`A_STATUS, r);
    check("zero load", 64'({r[9], r[5]}), 64'h3);
    u_host.wr_reg(`A_WDT_LOAD, 32'h1);
    #1 check("reload", 64'(o_watchdog_irq), 64'h0);
    wait_irq();
    u_host.wr_reg(`A_CLEAR, 32'h1);
    #1 check("wdt clear", 64'(o_watchdog_irq), 64'h0);
    // Fallback off keeps outputs
    u_host.wr_reg(`A_CTRL, 32'h1);
    u_host.wr_reg(`A_DO_SET_LO, 32'ha5a5);
    u_host.wr_reg(`A_WDT_LOAD, 32'h1);
    wait_irq();
    check("held outputs", o_dout, {SAFE[63:32], 32'ha5a5});
    u_host.wr_reg(`A_CTRL, 32'h0);
    u_host.wr_reg(`A_WDT_LOAD, 32'h1);
    repeat (60) @(posedge i_ref_clk);
    check("disabled wdt", 64'(o_watchdog_irq), 64'h0);
    // Flash images, busy flag, requests while busy
    u_host.set64(`A_PUP_SET_A, PUP);
    u_host.wr_reg(`A_SAFE_RB_REQ, 32'h1);
    u_host.rd_reg(`A_STATUS, r);
    check("busy", 64'(r[8]), 64'h1);
    u_host.wr_reg(`A_PUP_SET_A + 5'h3, 32'hffff);
    u_host.wr_reg(`A_PUP_RB_REQ, 32'h1);
    u_host.wait_idle();
    for (int i = 0; i < 4; i++) begin
      u_host.rd_reg(`A_RB_A + 5'(i), r);
      v[16*i +: 16] = r[15:0];
    end
    check("safety readback", v, SAFE);
    u_host.get64(`A_PUP_RB_REQ, v);
    check("default readback", v, PUP);
    // Change interrupts per bank
    u_host.wr_reg(`A_CTRL, 32'hc);
    for (int b = 0; b < 2; b++) begin
      chg[b] <= 1'b1;
      repeat (3) @(posedge i_ref_clk);
      chg[b] <= 1'b0;
      repeat (6) @(posedge i_ref_clk);
      check("change irq", 64'(birq[b]), 64'h1);
      u_host.rd_reg(`A_LATCH0 + 5'(b), r);
      check("latch", {32'h0, r}, {32'h0, DIN[32*b +: 32]});
      u_host.wr_reg(`A_CLEAR, 32'h2 << b);
      #1 check("change clear", 64'(birq[b]), 64'h0);
      u_host.rd_reg(`A_LATCH0 + 5'(b), r);
      check("latch erased", {32'h0, r}, 64'h0);
    end
    // Bridge local lines
    lint <= 2'b01;
    repeat (4) @(posedge i_ref_clk);
    u_host.rd_reg(`A_STATUS, r);
    check("local irq", 64'(r[7:6]), 64'h1);
    lint <= 2'b10;
    repeat (4) @(posedge i_ref_clk);
    u_host.rd_reg(`A_STATUS, r);
    check("local irq two", 64'(r[7:6]), 64'h2);
    // Second reset in mid-run
    i_rst <= 1'b1;
    lint <= 2'b00;
    repeat (5) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    check("dout after reset", o_dout, 64'h0);
    u_host.rd_reg(`A_STATUS, r);
    check("status after reset", {32'h0, r}, 64'h0);
    end_sim();
  end
endmodule
`default_nettype wire
